// File: core/gpio_pkg.sv
package gpio_pkg;

  // Port geometry
  localparam int PIN_COUNT = 16;

  // Register byte addresses
  localparam logic [31:0] ADDR_PIN_ENABLE    = 32'h01B00000;
  localparam logic [31:0] ADDR_PIN_DIRECTION = 32'h01B00004;
  localparam logic [31:0] ADDR_PIN_VALUE     = 32'h01B00008;
  localparam logic [31:0] ADDR_RISE_FLAGS    = 32'h01B00010;
  localparam logic [31:0] ADDR_RISE_MASK     = 32'h01B00014;
  localparam logic [31:0] ADDR_FALL_FLAGS    = 32'h01B00018;
  localparam logic [31:0] ADDR_FALL_MASK     = 32'h01B0001C;
  localparam logic [31:0] ADDR_GLOBAL_CTRL   = 32'h01B00020;
  localparam logic [31:0] ADDR_POLARITY      = 32'h01B00024;

  // Global control fields
  localparam int GC_LOGIC_MODE_BIT = 0;
  localparam int GC_AND_MODE_BIT   = 1;
  localparam int GC_WIDTH          = 2;

  // Reset values
  localparam logic [15:0]       DIRECTION_RESET = 16'h0000;
  localparam logic [15:0]       PIN_REG_RESET   = 16'h0000;
  localparam logic [GC_WIDTH-1:0] GC_RESET      = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register selector
  typedef enum {
    SEL_NONE,
    SEL_ENABLE,
    SEL_DIRECTION,
    SEL_VALUE,
    SEL_RISE_FLAGS,
    SEL_RISE_MASK,
    SEL_FALL_FLAGS,
    SEL_FALL_MASK,
    SEL_GLOBAL,
    SEL_POLARITY
  } reg_sel_e;

endpackage

// File: core/general_pin_port.sv
`timescale 1ns/10ps
// Operation
// - A pin is operated by the port only while its enable bit is 1.
// - An enabled pin is an input when its direction bit is 0 and an output when it is 1.
// - The direction bit has no effect on a pin whose enable bit is 0.
// - An output pin drives the level last written to its bit of the pin value register.
// - Reading the pin value register returns the current level of each input pin.
// - Pin activity raises interrupt and DMA events in selectable generation modes.
// - Direction bits reset to 0 and the upper sixteen direction bits read as zero.
// - Sixteen pins, 15 down to 0, each with enable and direction bits at its own position.
module general_pin_port
  import gpio_pkg::*;
#(
  parameter logic [PIN_COUNT-1:0] ENABLE_RESET = 16'h00FF
) (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [PIN_COUNT-1:0] general_pins_in,
  output logic [PIN_COUNT-1:0]      general_pins_out,
  output logic [PIN_COUNT-1:0]      general_pins_oe_n,
  output logic [PIN_COUNT-1:0]      pin_event,
  output logic                      logic_event
);

  // Address decode, shared by read and write paths
  function automatic reg_sel_e decode(input logic [31:0] addr);
    unique case (addr)
      ADDR_PIN_ENABLE:    decode = SEL_ENABLE;
      ADDR_PIN_DIRECTION: decode = SEL_DIRECTION;
      ADDR_PIN_VALUE:     decode = SEL_VALUE;
      ADDR_RISE_FLAGS:    decode = SEL_RISE_FLAGS;
      ADDR_RISE_MASK:     decode = SEL_RISE_MASK;
      ADDR_FALL_FLAGS:    decode = SEL_FALL_FLAGS;
      ADDR_FALL_MASK:     decode = SEL_FALL_MASK;
      ADDR_GLOBAL_CTRL:   decode = SEL_GLOBAL;
      ADDR_POLARITY:      decode = SEL_POLARITY;
      default:            decode = SEL_NONE;
    endcase
  endfunction

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    merge = old;
    if (strb[0]) merge[7:0]  = data[7:0];
    if (strb[1]) merge[15:8] = data[15:8];
  endfunction

  // Bit mask of the byte lanes written
  function automatic logic [15:0] lanes(input logic [3:0] strb);
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
  endfunction

  logic [PIN_COUNT-1:0] pin_enable;
  logic [PIN_COUNT-1:0] pin_direction;
  logic [PIN_COUNT-1:0] pin_value;
  logic [PIN_COUNT-1:0] rising_flags;
  logic [PIN_COUNT-1:0] rising_mask;
  logic [PIN_COUNT-1:0] falling_flags;
  logic [PIN_COUNT-1:0] falling_mask;
  logic [GC_WIDTH-1:0]  global_control;
  logic [PIN_COUNT-1:0] polarity;
  logic [PIN_COUNT-1:0] sync_stage1;
  logic [PIN_COUNT-1:0] sync_level;
  logic [PIN_COUNT-1:0] prev_level;
  logic [31:0]          aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 aw_held;
  logic                 w_held;
  logic                 do_write;
  reg_sel_e             wr_sel;
  reg_sel_e             rd_sel;
  logic [PIN_COUNT-1:0] input_mask;
  logic [PIN_COUNT-1:0] drive_mask;
  logic [PIN_COUNT-1:0] rise_edge;
  logic [PIN_COUNT-1:0] fall_edge;
  logic [PIN_COUNT-1:0] masked_any;
  logic [PIN_COUNT-1:0] mask_union;
  logic                 logic_cond;
  logic                 logic_cond_q;
  logic [31:0]          read_word;

  // Pin roles: direction only counts on enabled pins
  assign drive_mask = pin_enable & pin_direction;
  assign input_mask = pin_enable & ~pin_direction;

  // Two-stage synchroniser and edge history
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_stage1 <= PIN_REG_RESET;
      sync_level  <= PIN_REG_RESET;
      prev_level  <= PIN_REG_RESET;
    end else begin
      sync_stage1 <= general_pins_in;
      sync_level  <= sync_stage1;
      prev_level  <= sync_level;
    end
  end

  // Edge history warm-up: the synchroniser and history flops clear to 0 while idle pins may sit high,
  // so edges only count once prev_level holds a real synchronised sample, else a false edge follows reset
  localparam int HISTORY_DEPTH = 3;
  logic [HISTORY_DEPTH-1:0] settle;
  logic                     history_ok;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      settle <= '0;
    end else begin
      settle <= {settle[HISTORY_DEPTH-2:0], 1'b1};
    end
  end
  assign history_ok = settle[HISTORY_DEPTH-1];

  // Edges of enabled input pins only
  assign rise_edge = sync_level & ~prev_level & input_mask & {PIN_COUNT{history_ok}};
  assign fall_edge = ~sync_level & prev_level & input_mask & {PIN_COUNT{history_ok}};

  // Write channel capture, either order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      aw_held       <= 1'b0;
      aw_addr       <= 32'h00000000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel   = decode(aw_addr);

  // Write response, one cycle after both halves are held
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_enable     <= ENABLE_RESET;
      pin_direction  <= DIRECTION_RESET;
      pin_value      <= PIN_REG_RESET;
      rising_mask    <= PIN_REG_RESET;
      falling_mask   <= PIN_REG_RESET;
      global_control <= GC_RESET;
      polarity       <= PIN_REG_RESET;
    end else if (do_write) begin
      unique case (wr_sel)
        SEL_ENABLE:    pin_enable    <= merge(pin_enable, w_data, w_strb);
        SEL_DIRECTION: pin_direction <= merge(pin_direction, w_data, w_strb);
        SEL_VALUE:     pin_value     <= merge(pin_value, w_data, w_strb);
        SEL_RISE_MASK: rising_mask   <= merge(rising_mask, w_data, w_strb);
        SEL_FALL_MASK: falling_mask  <= merge(falling_mask, w_data, w_strb);
        SEL_POLARITY:  polarity      <= merge(polarity, w_data, w_strb);
        SEL_GLOBAL: begin
          if (w_strb[0]) global_control <= w_data[GC_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Change flags: write one to clear, a new edge wins over the clear
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rising_flags  <= PIN_REG_RESET;
      falling_flags <= PIN_REG_RESET;
    end else begin
      rising_flags  <= (rising_flags & ~((do_write && wr_sel == SEL_RISE_FLAGS) ?
                        (w_data[15:0] & lanes(w_strb)) : PIN_REG_RESET)) | rise_edge;
      falling_flags <= (falling_flags & ~((do_write && wr_sel == SEL_FALL_FLAGS) ?
                        (w_data[15:0] & lanes(w_strb)) : PIN_REG_RESET)) | fall_edge;
    end
  end

  // Pin drive, registered
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      general_pins_out  <= PIN_REG_RESET;
      general_pins_oe_n <= ~PIN_REG_RESET;
    end else begin
      general_pins_out  <= pin_value & drive_mask;
      general_pins_oe_n <= ~drive_mask;
    end
  end

  // Logic mode condition over masked flags
  assign masked_any = (rising_flags & rising_mask) | (falling_flags & falling_mask);
  assign mask_union = rising_mask | falling_mask;
  assign logic_cond = global_control[GC_AND_MODE_BIT] ?
                      ((mask_union != PIN_REG_RESET) && ((masked_any & mask_union) == mask_union)) :
                      (masked_any != PIN_REG_RESET);

  // Event generation: per-pin pass-through or combined logic event
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_event    <= PIN_REG_RESET;
      logic_event  <= 1'b0;
      logic_cond_q <= 1'b0;
    end else begin
      logic_cond_q <= logic_cond;
      if (global_control[GC_LOGIC_MODE_BIT]) begin
        pin_event   <= PIN_REG_RESET;
        logic_event <= logic_cond && !logic_cond_q;
      end else begin
        pin_event   <= (polarity & fall_edge) | (~polarity & rise_edge);
        logic_event <= 1'b0;
      end
    end
  end

  // Read data selection
  assign rd_sel = decode(s_axi_araddr);
  always_comb begin
    read_word = 32'h00000000;
    unique case (rd_sel)
      SEL_ENABLE:     read_word[15:0] = pin_enable;
      SEL_DIRECTION:  read_word[15:0] = pin_direction;
      SEL_VALUE:      read_word[15:0] = (pin_value & drive_mask) | (sync_level & input_mask);
      SEL_RISE_FLAGS: read_word[15:0] = rising_flags;
      SEL_RISE_MASK:  read_word[15:0] = rising_mask;
      SEL_FALL_FLAGS: read_word[15:0] = falling_flags;
      SEL_FALL_MASK:  read_word[15:0] = falling_mask;
      SEL_GLOBAL:     read_word[GC_WIDTH-1:0] = global_control;
      SEL_POLARITY:   read_word[15:0] = polarity;
      default:        read_word = 32'h00000000;
    endcase
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= read_word;
      s_axi_rresp   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  logic after_reset;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) after_reset <= 1'b1;
    else          after_reset <= 1'b0;
  end

  sequence s_aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_w_taken;
    s_axi_wvalid && s_axi_wready;
  endsequence

  oe_follow_cfg_a: assert property (general_pins_oe_n == ~$past(pin_enable & pin_direction))
    else $error("Output enable does not follow enable and direction");
  out_level_a: assert property ((general_pins_out & ~general_pins_oe_n) ==
                                ($past(pin_value) & ~general_pins_oe_n))
    else $error("Driven pin level differs from written value");
  value_read_a: assert property (s_axi_arvalid && s_axi_arready && rd_sel == SEL_VALUE |=>
                                 (s_axi_rdata[15:0] & $past(input_mask)) == ($past(sync_level) & $past(input_mask)))
    else $error("Input pin readback wrong");
  rise_flag_a: assert property (rise_edge != PIN_REG_RESET |=>
                                (rising_flags & $past(rise_edge)) == $past(rise_edge))
    else $error("Rising edge did not set its flag");
  pass_event_a: assert property (!global_control[GC_LOGIC_MODE_BIT] && $stable(global_control) |=>
                                 pin_event == $past((polarity & fall_edge) | (~polarity & rise_edge)))
    else $error("Pass-through event mismatch");
  dir_upper_a: assert property (s_axi_arvalid && s_axi_arready && rd_sel == SEL_DIRECTION |=>
                                s_axi_rdata[31:16] == 16'h0000)
    else $error("Reserved direction bits not zero");
  dir_reset_a: assert property (after_reset |-> pin_direction == DIRECTION_RESET)
    else $error("Direction not cleared by reset");
  sync_delay_a: assert property ((reset_n && $stable(general_pins_in))[*3] |-> sync_level == general_pins_in)
    else $error("Synchroniser latency wrong");
  no_flag_disabled_a: assert property (((rising_flags & ~$past(rising_flags)) & ~$past(pin_enable)) == 16'h0000)
    else $error("Disabled pin raised a flag");
  write_resp_a: assert property ((s_aw_taken ##0 s_w_taken) |-> ##[1:2] s_axi_bvalid)
    else $error("Write response missing");
  early_edge_a: assert property (!history_ok |=> pin_event == PIN_REG_RESET)
    else $error("Pin event before edge history settled");

endmodule

// File: tb/pin_partner.sv
`timescale 1ns/10ps
module pin_partner
  import gpio_pkg::*;
(
  input  wire logic [PIN_COUNT-1:0] general_pins_out,
  input  wire logic [PIN_COUNT-1:0] general_pins_oe_n,
  input  wire logic [PIN_COUNT-1:0] device_level,
  output logic [PIN_COUNT-1:0]      general_pins_in
);
  // Wire level: the port where its enable is low, the far device elsewhere
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      general_pins_in[i] = general_pins_oe_n[i] ? device_level[i] : general_pins_out[i];
    end
  end
endmodule

// File: tb/general_pin_port_test.sv
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module general_pin_port_test
  import gpio_pkg::*;
;
  localparam logic [15:0] EN_RST = 16'h00FF;
  logic                 clock;
  logic                 reset_n;
  logic [31:0]          s_axi_awaddr;
  logic                 s_axi_awvalid;
  logic                 s_axi_awready;
  logic [31:0]          s_axi_wdata;
  logic [3:0]           s_axi_wstrb;
  logic                 s_axi_wvalid;
  logic                 s_axi_wready;
  logic [1:0]           s_axi_bresp;
  logic                 s_axi_bvalid;
  logic                 s_axi_bready;
  logic [31:0]          s_axi_araddr;
  logic                 s_axi_arvalid;
  logic                 s_axi_arready;
  logic [31:0]          s_axi_rdata;
  logic [1:0]           s_axi_rresp;
  logic                 s_axi_rvalid;
  logic                 s_axi_rready;
  logic [PIN_COUNT-1:0] general_pins_in;
  logic [PIN_COUNT-1:0] general_pins_out;
  logic [PIN_COUNT-1:0] general_pins_oe_n;
  logic [PIN_COUNT-1:0] pin_event;
  logic                 logic_event;
  logic [PIN_COUNT-1:0] device_level;
  int                   error_cnt;
  int                   tests_run;
  int                   cycles;

  general_pin_port #(.ENABLE_RESET(EN_RST)) u_general_pin_port (.clock(clock), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .general_pins_in(general_pins_in),
    .general_pins_out(general_pins_out), .general_pins_oe_n(general_pins_oe_n),
    .pin_event(pin_event), .logic_event(logic_event));

  pin_partner u_pin_partner (.general_pins_out(general_pins_out), .general_pins_oe_n(general_pins_oe_n),
    .device_level(device_level), .general_pins_in(general_pins_in));

  // Clock and hang guard
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Bus write: address and data offered together, each released when taken
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    r = 2'h3;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        done = 1;
      end
    end
    s_axi_bready <= 1'b0;
    `CHK({s_axi_awvalid, s_axi_wvalid}, 2'b00)
  endtask

  // Bus read: rready held up until the answer is sampled
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    d = 32'hFFFFFFFF;
    r = 2'h3;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        done = 1;
      end
    end
    s_axi_rready <= 1'b0;
    `CHK(s_axi_arvalid, 1'b0)
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    `CHK(r, RESP_OKAY)
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    `CHK(r, RESP_OKAY)
    `CHK(d, e)
  endtask

  // Counts event pulses over a window; pulses stand one cycle so each edge sees one at most
  task automatic watch(input int n, output logic [15:0] seen, output int pulses, output int lpulses);
    seen = 16'h0000;
    pulses = 0;
    lpulses = 0;
    repeat (n) begin
      @(posedge clock);
      seen = seen | pin_event;
      if (pin_event !== 16'h0000) pulses++;
      if (logic_event === 1'b1) lpulses++;
    end
  endtask

  task automatic test_reset();
    `CHK(general_pins_oe_n, 16'hFFFF)
    `CHK(general_pins_out, 16'h0000)
    rd_chk(ADDR_PIN_ENABLE, {16'h0000, EN_RST});
    rd_chk(ADDR_PIN_DIRECTION, 32'h00000000);
    rd_chk(ADDR_GLOBAL_CTRL, 32'h00000000);
  endtask

  task automatic test_drive();
    wr(ADDR_PIN_ENABLE, 32'h0000FFFF);
    wr(ADDR_PIN_DIRECTION, 32'hFFFF00F0);
    rd_chk(ADDR_PIN_DIRECTION, 32'h000000F0);
    wr(ADDR_PIN_VALUE, 32'h0000A5A5);
    repeat (4) @(posedge clock);
    `CHK(general_pins_out, 16'h00A0)
    `CHK(general_pins_oe_n, 16'hFF0F)
    rd_chk(ADDR_PIN_VALUE, 32'h00003CAC);
  endtask

  task automatic test_disabled();
    wr(ADDR_PIN_ENABLE, 32'h000000FF);
    wr(ADDR_PIN_DIRECTION, 32'h0000FF00);
    repeat (3) @(posedge clock);
    `CHK(general_pins_oe_n, 16'hFFFF)
    `CHK(general_pins_out, 16'h0000)
    rd_chk(ADDR_PIN_VALUE, 32'h0000003C);
  endtask

  task automatic test_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(32'h01B0000C, 32'hFFFFFFFF, r);
    `CHK(r, RESP_SLVERR)
    axi_read(32'h01B0000C, d, r);
    `CHK(r, RESP_SLVERR)
    `CHK(d, 32'h00000000)
  endtask

  task automatic test_events();
    logic [15:0] seen;
    int          p;
    int          lp;
    wr(ADDR_PIN_DIRECTION, 32'h00000000);
    device_level <= 16'h0000;
    repeat (6) @(posedge clock);
    wr(ADDR_RISE_FLAGS, 32'h0000FFFF);
    wr(ADDR_FALL_FLAGS, 32'h0000FFFF);
    device_level <= 16'h0101;
    watch(8, seen, p, lp);
    `CHK(seen, 16'h0001)
    `CHK(p, 1)
    rd_chk(ADDR_RISE_FLAGS, 32'h00000001);
    wr(ADDR_RISE_FLAGS, 32'h00000001);
    rd_chk(ADDR_RISE_FLAGS, 32'h00000000);
    device_level <= 16'h0000;
    watch(8, seen, p, lp);
    `CHK(seen, 16'h0000)
    rd_chk(ADDR_FALL_FLAGS, 32'h00000001);
    wr(ADDR_FALL_FLAGS, 32'h00000001);
    wr(ADDR_RISE_MASK, 32'h00000002);
    wr(ADDR_GLOBAL_CTRL, 32'h00000001);
    device_level <= 16'h0002;
    watch(8, seen, p, lp);
    `CHK(lp, 1)
  endtask

  // Falling polarity in pass-through mode, byte-lane write, then AND mode needing both masked pins
  task automatic test_modes();
    logic [15:0] seen;
    int          p;
    int          lp;
    wr(ADDR_GLOBAL_CTRL, 32'h00000000);
    wr(ADDR_POLARITY, 32'h00000002);
    device_level <= 16'h0000;
    watch(8, seen, p, lp);
    `CHK(seen, 16'h0002)
    `CHK(p, 1)
    s_axi_wstrb <= 4'h2;
    wr(ADDR_POLARITY, 32'h0000FFFF);
    s_axi_wstrb <= 4'hF;
    rd_chk(ADDR_POLARITY, 32'h0000FF02);
    wr(ADDR_RISE_FLAGS, 32'h0000FFFF);
    wr(ADDR_FALL_FLAGS, 32'h0000FFFF);
    wr(ADDR_RISE_MASK, 32'h00000003);
    wr(ADDR_GLOBAL_CTRL, 32'h00000003);
    device_level <= 16'h0001;
    watch(8, seen, p, lp);
    `CHK(lp, 0)
    device_level <= 16'h0003;
    watch(8, seen, p, lp);
    `CHK(lp, 1)
  endtask

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    s_axi_awaddr = 32'h00000000;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 32'h00000000;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    device_level = 16'h3C3C;
    error_cnt = 0;
    tests_run = 0;
    cycles = 0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    test_reset();
    test_drive();
    test_disabled();
    test_unmapped();
    test_events();
    test_modes();
    final_report();
  end
endmodule
